// ===== shared/cls_pkg.sv
package cls_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int POR_FAST_NS    = 4000;
  localparam int POR_STD_NS     = 100000;
  localparam int ERR_TMO_NS     = 230000;
  localparam int POR_FAST_CYC   = (POR_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POR_STD_CYC    = (POR_STD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ERR_TMO_CYC    = (ERR_TMO_NS * 1000) / CLK_PERIOD_PS;
  localparam int INIT_CYCLES    = 3192;

  // Frame layout: word 0 carries options, last word is the XOR check
  localparam int LOAD_WORDS     = 16;
  localparam int OPT_AUTO_BIT   = 0;
  localparam int OPT_UCLK_BIT   = 1;
  localparam int OPT_SDONE_BIT  = 2;
  localparam int TMR_W          = 17;
  localparam int WCNT_W         = 8;
  localparam int DATA_W         = 8;
  localparam int BITS_W         = 3;

  localparam logic [TMR_W-1:0]  TMR_RST  = 17'h0_0000;
  localparam logic [WCNT_W-1:0] WCNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_RST = 8'h00;
  localparam logic [3:0]        SEL_RST  = 4'h0;

  typedef enum logic [5:0] {
    ST_POR   = 6'b00_0001,
    ST_RESET = 6'b00_0010,
    ST_LOAD  = 6'b00_0100,
    ST_ERROR = 6'b00_1000,
    ST_INIT  = 6'b01_0000,
    ST_USER  = 6'b10_0000
  } cls_st_t;

  typedef struct packed {
    logic sdone_en;
    logic uclk_en;
    logic auto_en;
  } cls_opt_t;

  // Pin levels that pass the two-flop synchroniser
  typedef struct packed {
    logic       restart_n;
    logic       status;
    logic       done;
    logic       uclk;
    logic       tgl;
    logic [3:0] scheme;
  } cls_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] sh;
    logic [BITS_W-1:0] bits;
    logic [DATA_W-1:0] word;
    logic              tgl;
  } cls_link_t;

  typedef struct packed {
    cls_st_t            st;
    logic [TMR_W-1:0]   tmr;
    logic [WCNT_W-1:0]  wcnt;
    logic [DATA_W-1:0]  csum;
    cls_opt_t           opt;
    logic [3:0]         scheme;
    logic               tgl_seen;
    logic               uclk_prev;
    logic               status_oe;
    logic               done_oe;
    logic               sdone_oe;
    logic               io_hiz;
    logic               pullup_en;
    logic               link_en;
  } cls_seq_t;

endpackage

// ===== hw/cls_sync.sv
`timescale 1ns/1ps
module cls_sync (
  input  wire logic              clk,     // Sampling clock
  input  wire logic              reset_n, // Async reset, active low
  input  wire cls_pkg::cls_pins_t d,      // Asynchronous levels
  output cls_pkg::cls_pins_t     q        // Synchronised levels
);
  import cls_pkg::*;

  cls_pins_t meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== hw/cls_link.sv
`timescale 1ns/1ps
module cls_link (
  input  wire logic              cfg_bit_clock, // Link clock from the host
  input  wire logic              link_rst_n,    // Held low outside the load stage
  input  wire logic              byte_mode,     // Static while loading
  input  wire logic [7:0]        cfg_data,      // Data bus, bit 0 in serial mode
  output logic [7:0]             word,          // Last complete word
  output logic                   tgl            // Flips once per word
);
  import cls_pkg::*;

  cls_link_t q, d;

  always_comb begin
    d = q;
    if (byte_mode) begin
      d.word = cfg_data;
      d.tgl  = ~q.tgl;
    end else begin
      d.sh   = {q.sh[DATA_W-2:0], cfg_data[0]};
      d.bits = q.bits + 3'h1;
      if (q.bits == 3'h7) begin
        d.word = {q.sh[DATA_W-2:0], cfg_data[0]};
        d.tgl  = ~q.tgl;
      end
    end
  end

  // Word stays stable for at least one link period after the toggle
  always_ff @(posedge cfg_bit_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign word = q.word;
  assign tgl  = q.tgl;
endmodule

// ===== hw/cls_seq.sv
`timescale 1ns/1ps
module cls_seq #(
  parameter int POR_STD_CYC_P = cls_pkg::POR_STD_CYC,
  parameter int ERR_TMO_CYC_P = cls_pkg::ERR_TMO_CYC
) (
  input  wire logic       clk,                 // Internal oscillator clock
  input  wire logic       reset_n,             // Power-on reset, active low
  input  wire logic [3:0] scheme_select,       // Scheme strap pins
  input  wire logic       cfg_restart_n,       // Restart pin, active low
  input  wire logic       cfg_bit_clock,       // Configuration bit clock
  input  wire logic [7:0] cfg_data,            // Configuration data pins
  input  wire logic       user_startup_clock,  // Optional init clock pin
  input  wire logic       cfg_status_n_i,      // Status line level
  output logic            cfg_status_n_o,      // Status drive value
  output logic            cfg_status_n_oe,     // Status pull-down enable
  input  wire logic       load_complete_i,     // Load complete line level
  output logic            load_complete_o,     // Load complete drive value
  output logic            load_complete_oe,    // Load complete pull-down enable
  input  wire logic       startup_complete_i,  // Start-up line level
  output logic            startup_complete_o,  // Start-up drive value
  output logic            startup_complete_oe, // Start-up pull-down enable
  output logic            user_io_hiz,         // User pins floated
  output logic            weak_pullup_en,      // Weak pull-ups on
  output logic            user_clk_claimed,    // Start-up clock pin in use
  output logic            user_mode,           // Device in user mode
  output logic            cfg_ready            // Load stage open
);
  import cls_pkg::*;

  localparam logic [TMR_W-1:0]  POR_FAST_T = TMR_W'(POR_FAST_CYC - 1);
  localparam logic [TMR_W-1:0]  POR_STD_T  = TMR_W'(POR_STD_CYC_P - 1);
  localparam logic [TMR_W-1:0]  ERR_T      = TMR_W'(ERR_TMO_CYC_P - 1);
  localparam logic [TMR_W-1:0]  INIT_T     = TMR_W'(INIT_CYCLES - 1);
  localparam logic [WCNT_W-1:0] LAST_W     = WCNT_W'(LOAD_WORDS - 1);

  cls_seq_t  q, d;
  cls_pins_t pins_a, pins_s;
  logic [7:0] link_word;
  logic       link_tgl;
  logic       link_rst_n;

  function automatic logic fast_por(input logic [3:0] sel);
    case (sel)
      4'b1101, 4'b1011, 4'b1100, 4'b1110, 4'b0011, 4'b0100: fast_por = 1'b1;
      default:                                               fast_por = 1'b0;
    endcase
  endfunction

  function automatic logic byte_scheme(input logic [3:0] sel);
    case (sel)
      4'b0011, 4'b0100, 4'b0001, 4'b0010: byte_scheme = 1'b1;
      default:                            byte_scheme = 1'b0;
    endcase
  endfunction

  function automatic logic host_scheme(input logic [3:0] sel);
    case (sel)
      4'b1100, 4'b1110, 4'b1000, 4'b0000: host_scheme = 1'b1;
      default:                            host_scheme = byte_scheme(sel);
    endcase
  endfunction

  always_comb begin
    pins_a.restart_n = cfg_restart_n;
    pins_a.status    = cfg_status_n_i;
    pins_a.done      = load_complete_i;
    pins_a.uclk      = user_startup_clock;
    pins_a.tgl       = link_tgl;
    pins_a.scheme    = scheme_select;
  end

  cls_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (pins_a),
    .q       (pins_s)
  );

  // Link logic is held in reset outside the load stage, so a stopped
  // bit clock never leaves a half-built word behind
  assign link_rst_n = q.link_en;

  cls_link u_link (
    .cfg_bit_clock (cfg_bit_clock),
    .link_rst_n    (link_rst_n),
    .byte_mode     (byte_scheme(q.scheme)),
    .cfg_data      (cfg_data),
    .word          (link_word),
    .tgl           (link_tgl)
  );

  always_comb begin
    logic             word_new;
    logic             tick;
    logic [TMR_W-1:0] por_t;
    word_new    = 1'b0;
    tick        = 1'b0;
    por_t       = TMR_RST;
    d           = q;
    d.tgl_seen  = pins_s.tgl;
    d.uclk_prev = pins_s.uclk;
    word_new    = pins_s.tgl ^ q.tgl_seen;
    // Init clock source; the start-up pin is only looked at here
    tick        = q.opt.uclk_en ? (pins_s.uclk & ~q.uclk_prev) : 1'b1;
    por_t       = fast_por(q.scheme) ? POR_FAST_T : POR_STD_T;

    case (q.st)
      ST_POR: begin
        d.scheme = pins_s.scheme;
        d.tmr    = q.tmr + 17'h0_0001;
        if (q.tmr >= por_t) begin
          d.st  = ST_RESET;
          d.tmr = TMR_RST;
        end
      end
      ST_RESET: begin
        if (pins_s.restart_n) begin
          d.st   = ST_LOAD;
          d.wcnt = WCNT_RST;
          d.csum = WORD_RST;
        end
      end
      ST_LOAD: begin
        // Words are taken only once the shared status line reads high
        if (word_new && pins_s.status) begin
          d.wcnt = q.wcnt + 8'h01;
          d.csum = q.csum ^ link_word;
          if (q.wcnt == WCNT_RST) begin
            d.opt.auto_en  = link_word[OPT_AUTO_BIT];
            d.opt.uclk_en  = link_word[OPT_UCLK_BIT];
            d.opt.sdone_en = link_word[OPT_SDONE_BIT];
          end
          if (q.wcnt == LAST_W) begin
            d.tmr = TMR_RST;
            d.st  = (link_word == q.csum) ? ST_INIT : ST_ERROR;
          end
        end
      end
      ST_ERROR: begin
        if (q.opt.auto_en) begin
          d.tmr = q.tmr + 17'h0_0001;
          if (q.tmr >= ERR_T) begin
            d.st   = ST_LOAD;
            d.tmr  = TMR_RST;
            d.wcnt = WCNT_RST;
            d.csum = WORD_RST;
          end
        end
      end
      ST_INIT: begin
        // Counting starts when the released done line is seen high
        if (pins_s.done && tick) begin
          d.tmr = q.tmr + 17'h0_0001;
          if (q.tmr == INIT_T) begin
            d.st = ST_USER;
          end
        end
      end
      ST_USER: begin
        d.st = ST_USER;
      end
      default: begin
        d.st = ST_POR;
      end
    endcase

    // Restart pin wins over every stage except power-on reset
    if (!pins_s.restart_n && q.st != ST_POR) begin
      d.st   = ST_RESET;
      d.tmr  = TMR_RST;
      d.wcnt = WCNT_RST;
      d.csum = WORD_RST;
      d.opt  = '0;
    end

    d.status_oe = (d.st == ST_POR) || (d.st == ST_RESET) || (d.st == ST_ERROR);
    d.done_oe   = (d.st != ST_INIT) && (d.st != ST_USER);
    d.sdone_oe  = d.opt.sdone_en && (d.st != ST_USER);
    d.io_hiz    = (d.st == ST_POR) ? host_scheme(d.scheme) : (d.st != ST_USER);
    d.pullup_en = (d.st != ST_POR) && (d.st != ST_USER);
    d.link_en   = (d.st == ST_LOAD);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q           <= '0;
      q.st        <= ST_POR;
      q.scheme    <= SEL_RST;
      q.status_oe <= 1'b1;
      q.done_oe   <= 1'b1;
      q.io_hiz    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Open-drain: drive value is always low, only the enable moves
  assign cfg_status_n_o      = 1'b0;
  assign load_complete_o     = 1'b0;
  assign startup_complete_o  = 1'b0;
  assign cfg_status_n_oe     = q.status_oe;
  assign load_complete_oe    = q.done_oe;
  assign startup_complete_oe = q.sdone_oe;
  assign user_io_hiz         = q.io_hiz;
  assign weak_pullup_en      = q.pullup_en;
  assign user_clk_claimed    = q.opt.uclk_en;
  assign user_mode           = (q.st == ST_USER);
  assign cfg_ready           = q.link_en;
endmodule

// ===== testbench/cls_seq_chk.sv
`timescale 1ns/1ps
module cls_chk (
  input wire logic clk,                 // Clock
  input wire logic reset_n,             // Reset
  input wire logic cfg_restart_n,       // Restart
  input wire logic cfg_status_n_o,      // Drive
  input wire logic cfg_status_n_oe,     // Pull low
  input wire logic load_complete_i,     // Line
  input wire logic load_complete_o,     // Drive
  input wire logic load_complete_oe,    // Pull low
  input wire logic startup_complete_o,  // Drive
  input wire logic startup_complete_oe, // Pull low
  input wire logic user_io_hiz,         // Floated
  input wire logic weak_pullup_en,      // Pull-ups
  input wire logic user_clk_claimed,    // Clock option
  input wire logic user_mode,           // User mode
  input wire logic cfg_ready            // Loading
);
  logic [11:0] hi_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Saturates so a long user-clock init never wraps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_q <= 12'h000;
    end else if (!load_complete_i) begin
      hi_q <= 12'h000;
    end else if (hi_q != 12'hfff) begin
      hi_q <= hi_q + 12'h001;
    end
  end
  sequence s_restart_held;
    cfg_restart_n ##1 !cfg_restart_n [*6];
  endsequence
  sequence s_held_reset;
    cfg_status_n_oe && load_complete_oe && !user_mode;
  endsequence
  a_drive_low_only: assert property (!cfg_status_n_o && !load_complete_o && !startup_complete_o)
    else $error("open-drain line driven high");
  a_por_held: assert property ($rose(reset_n) |-> cfg_status_n_oe && load_complete_oe && !cfg_ready)
    else $error("lines free right after reset");
  a_restart_resets: assert property (s_restart_held |-> s_held_reset)
    else $error("restart did not reset");
  a_ready_state: assert property (cfg_ready |-> !cfg_status_n_oe && user_io_hiz && weak_pullup_en)
    else $error("load stage with bad pins");
  a_error_done_low: assert property (cfg_status_n_oe |-> load_complete_oe)
    else $error("done released with status low");
  a_done_from_load: assert property ($fell(load_complete_oe) |-> $past(cfg_ready) && !user_mode)
    else $error("done released outside loading");
  a_init_count: assert property ($rose(user_mode) && !user_clk_claimed |-> hi_q >= 12'hc78 && hi_q <= 12'hc80)
    else $error("wrong init length");
  a_user_pins: assert property (user_mode |-> !user_io_hiz && !weak_pullup_en && !startup_complete_oe)
    else $error("user mode pins wrong");
  a_flag_in_load: assert property ($rose(startup_complete_oe) |-> load_complete_oe && !user_mode)
    else $error("start-up flag low outside load");
  a_release_opens: assert property ($fell(cfg_status_n_oe) |-> cfg_ready)
    else $error("status released outside the load stage");
endmodule

bind cls_seq cls_chk u_chk (
  .clk                 (clk),
  .reset_n             (reset_n),
  .cfg_restart_n       (cfg_restart_n),
  .cfg_status_n_o      (cfg_status_n_o),
  .cfg_status_n_oe     (cfg_status_n_oe),
  .load_complete_i     (load_complete_i),
  .load_complete_o     (load_complete_o),
  .load_complete_oe    (load_complete_oe),
  .startup_complete_o  (startup_complete_o),
  .startup_complete_oe (startup_complete_oe),
  .user_io_hiz         (user_io_hiz),
  .weak_pullup_en      (weak_pullup_en),
  .user_clk_claimed    (user_clk_claimed),
  .user_mode           (user_mode),
  .cfg_ready           (cfg_ready)
);

// ===== testbench/cls_host.sv
`timescale 1ns/1ps
module cls_host (
  output logic       cfg_bit_clock, // Link clock, idle low
  output logic [7:0] cfg_data       // Data bus
);
  initial begin
    cfg_bit_clock = 1'b0;
    cfg_data = 8'h00;
  end
  // One rising edge every 80 ns, data set up half a period before it
  task automatic pulse(input logic [7:0] v);
    cfg_data = v;
    #40 cfg_bit_clock = 1'b1;
    #40 cfg_bit_clock = 1'b0;
  endtask
  // Odd start offset keeps the link edges off the core clock edges;
  // serial mode sends MSB first on bit 0 with junk on the unused lines
  task automatic send(input logic [127:0] f, input logic serial);
    #7.3;
    for (int i = 0; i < 16; i++) begin
      if (serial) begin
        for (int b = 7; b >= 0; b--) begin
          pulse({{7{~f[8*i + b]}}, f[8*i + b]});
        end
      end else begin
        pulse(f[8*i +: 8]);
      end
    end
    // A released bus never shows the stale byte
    cfg_data = ~cfg_data;
  endtask
endmodule

// ===== testbench/config_load_sequencer_test.sv
`timescale 1ns/1ps
module config_load_sequencer_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] scheme = 4'h1;
  logic restart_n = 1'b1;
  logic uclk = 1'b0;
  wire bclk, st_oe, dn_oe, sd_oe, hiz, pu, um, rdy, uc;
  wire [7:0] bdata;
  wire [7:0] obs = {st_oe, dn_oe, sd_oe, hiz, pu, um, rdy, uc};
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  logic [15:0] p;
  event look;
  always #2 clk = ~clk;
  cls_host host (.cfg_bit_clock(bclk), .cfg_data(bdata));
  cls_seq #(.POR_STD_CYC_P(50), .ERR_TMO_CYC_P(40)) DUT (
    .clk(clk), .reset_n(reset_n), .scheme_select(scheme), .cfg_restart_n(restart_n),
    .cfg_bit_clock(bclk), .cfg_data(bdata), .user_startup_clock(uclk),
    .cfg_status_n_i(!st_oe), .cfg_status_n_o(), .cfg_status_n_oe(st_oe),
    .load_complete_i(!dn_oe), .load_complete_o(), .load_complete_oe(dn_oe),
    .startup_complete_i(!sd_oe), .startup_complete_o(), .startup_complete_oe(sd_oe),
    .user_io_hiz(hiz), .weak_pullup_en(pu), .user_clk_claimed(uc), .user_mode(um), .cfg_ready(rdy));
  task automatic check(logic [7:0] seen, logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: outputs %b, expected %b", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_bit(int b, logic v, int lim);
    while (obs[b] !== v && lim > 0) begin
      wt(1);
      lim--;
    end
  endtask
  task automatic note(logic [7:0] m, logic [7:0] e);
    exp_q.push_back({m, e});
    -> look;
  endtask
  always @(look) begin
    p = exp_q.pop_front();
    check(obs & p[15:8], p[7:0]);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      bad_count++;
      results();
    end
  end
  function automatic logic [127:0] frame(logic [7:0] opt, logic bad);
    logic [7:0] x;
    frame[7:0] = opt;
    x = opt;
    for (int i = 1; i < 15; i++) begin
      frame[8*i +: 8] = 8'($urandom);
      x ^= frame[8*i +: 8];
    end
    frame[127:120] = x ^ {7'h00, bad};
  endfunction
  task automatic por(logic [3:0] s, int n, logic h);
    reset_n = 1'b0;
    scheme = s;
    wt(6);
    note(8'hff, 8'hd0);
    reset_n = 1'b1;
    wt(n);
    note(8'h12, {3'h0, h, 4'h0});
    wait_bit(1, 1'b1, 40);
    note(8'hff, 8'h5a);
  endtask
  task automatic restart();
    restart_n = 1'b0;
    wt(10);
    note(8'hf4, 8'hd0);
    // Start-up clock keeps running while the status line is held low
    for (int i = 0; i < 58; i++) begin
      uclk = ~uclk;
      wt(2);
    end
    restart_n = 1'b1;
    wait_bit(1, 1'b1, 10);
    note(8'hff, 8'h5a);
  endtask
  initial begin
    void'($urandom(93960));
    por(4'h1, 45, 1'b1);
    host.send(frame(8'h05, 1'b0), 1'b0);
    wait_bit(6, 1'b0, 20);
    note(8'hfd, 8'h38);
    wt(3150);
    note(8'h04, 8'h00);
    wait_bit(2, 1'b1, 60);
    note(8'hfd, 8'h04);
    restart();
    host.send(frame(8'h01, 1'b1), 1'b0);
    wait_bit(7, 1'b1, 20);
    note(8'hd4, 8'hd0);
    wt(30);
    note(8'h80, 8'h80);
    wait_bit(1, 1'b1, 20);
    note(8'hff, 8'h5a);
    host.send(frame(8'h00, 1'b0), 1'b0);
    wait_bit(6, 1'b0, 20);
    note(8'he0, 8'h00);
    wait_bit(2, 1'b1, 3300);
    note(8'h04, 8'h04);
    restart();
    host.send(frame(8'h00, 1'b1), 1'b0);
    wt(80);
    note(8'hc2, 8'hc0);
    restart();
    host.send(frame(8'h02, 1'b0), 1'b0);
    wait_bit(6, 1'b0, 20);
    note(8'hfd, 8'h19);
    wt(3400);
    note(8'h04, 8'h00);
    for (int i = 0; i < 3200; i++) begin
      wt(3);
      uclk = 1'b1;
      wt(3);
      uclk = 1'b0;
      if (i == 3189) begin
        note(8'h04, 8'h00);
      end
    end
    note(8'hfd, 8'h05);
    por(4'h3, 990, 1'b1);
    // Serial scheme without host-driven pins: user pins not floated in the power-on reset stage
    por(4'h9, 45, 1'b0);
    host.send(frame(8'h04, 1'b0), 1'b1);
    wait_bit(6, 1'b0, 20);
    note(8'hfd, 8'h38);
    wait_bit(2, 1'b1, 3300);
    note(8'hff, 8'h04);
    // Lets the checking process take the last note before the run ends
    wt(2);
    results();
  end
endmodule
